/* rtl/msie_regs.svh */
// Register offsets, field positions and reset values of the executor.
`ifndef MSIE_REGS_SVH
`define MSIE_REGS_SVH

// Byte offsets of the bus-visible registers.
`define MSIE_OFS_CTRL         5'h00
`define MSIE_OFS_STATUS       5'h04
`define MSIE_OFS_HALT_PC      5'h08
`define MSIE_OFS_MAIN_SP      5'h0C
`define MSIE_OFS_PROC_SP      5'h10
`define MSIE_OFS_CONTROL      5'h14

// Control register fields.
`define MSIE_CTRL_RESUME      0
`define MSIE_CTRL_EVENT_CLR   1
`define MSIE_CTRL_BREAKPOINT_INSTR_LOCK   2
`define MSIE_CTRL_LOCKUP_CLR  3

// Status register fields.
`define MSIE_ST_FLAGS_LSB     0
`define MSIE_ST_PRIORITY_MASK_BIT       4
`define MSIE_ST_HALTED        5
`define MSIE_ST_LOCKUP        6
`define MSIE_ST_EVENT         7
`define MSIE_ST_ORDER_HOLD    8
`define MSIE_ST_SYNC_HOLD     9

// Condition flag positions inside the four-bit flag field.
`define MSIE_FLAG_Z           2

// Special register selector codes.
`define MSIE_SYSM_MAIN_SP     8'h08
`define MSIE_SYSM_PROC_SP     8'h09
`define MSIE_SYSM_PRIORITY_MASK_BIT     8'h10
`define MSIE_SYSM_CONTROL     8'h14

// Reset values and fixed masks.
`define MSIE_RST_WORD         32'h0000_0000
`define MSIE_RST_CONTROL      2'h0
`define MSIE_SP_ALIGN_MASK    32'hFFFF_FFFC
`define MSIE_LINK_THUMB       32'h0000_0001

`endif

/* rtl/msie_pkg.sv */
// Types shared by the system instruction executor modules.
package msie_pkg;

  // Instruction classes handed over by the decode stage.
  typedef enum logic [3:0] {
    op_nop, op_breakpoint_instr, op_irq_mask_set_instr, op_irq_mask_clear_instr, op_dmb, op_dsb, op_isb,
    op_mrs, op_msr, op_sev, op_beq, op_bl, op_blx
  } msie_op_t;

  // Barrier tracker states.
  typedef enum logic [1:0] {
    bar_idle, bar_order_wait, bar_sync_wait
  } msie_bar_state_t;

  // Whole state of the barrier tracker.
  typedef struct packed {
    msie_bar_state_t state;
    logic            flush;
  } msie_bar_t;

  // Whole state of the executor core.
  typedef struct packed {
    logic [3:0]  flags;
    logic        priority_mask_bit;
    logic        halted;
    logic        lockup;
    logic        local_event;
    logic        breakpoint_instr_lock;
    logic [31:0] halt_pc;
    logic [31:0] main_sp;
    logic [31:0] proc_sp;
    logic [1:0]  control;
    logic        result_valid;
    logic [31:0] result_data;
    logic        branch_taken;
    logic [31:0] branch_target;
    logic [31:0] link_reg;
    logic        event_out;
    logic        hard_fault;
    logic        bus_ack;
    logic [31:0] bus_rdata;
  } msie_core_t;

endpackage

/* rtl/msie_barrier.sv */
// Barrier tracker: memory ordering, synchronisation and pipeline flush.
`timescale 1ns/1ps
module msie_barrier (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic dmb_start,
  input  wire logic dsb_start,
  input  wire logic isb_start,
  input  wire logic mem_pending,
  output logic      order_hold,
  output logic      sync_hold,
  output logic      pipeline_flush
);
  import msie_pkg::*;

  msie_bar_t q;
  msie_bar_t next_q;

  // Next state: a barrier waits until no earlier access is still pending.
  always_comb begin
    next_q       = q;
    next_q.flush = isb_start;
    unique case (q.state)
      bar_idle: begin
        if (dsb_start) begin
          next_q.state = bar_sync_wait;
        end else if (dmb_start) begin
          next_q.state = bar_order_wait;
        end
      end
      bar_order_wait: begin
        if (dsb_start) begin
          next_q.state = bar_sync_wait;
        end else if (!mem_pending) begin
          next_q.state = bar_idle;
        end
      end
      bar_sync_wait: begin
        if (!mem_pending) begin
          next_q.state = bar_idle;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '{state: bar_idle, flush: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // Holds are decoded from the state; the flush is a registered pulse.
  assign order_hold     = (q.state == bar_order_wait);
  assign sync_hold      = (q.state == bar_sync_wait);
  assign pipeline_flush = q.flush;
endmodule // msie_barrier

/* rtl/msie_core.sv */
// System and miscellaneous instruction executor with its register slave.
`timescale 1ns/1ps
`include "msie_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Breakpoint halts the core for a debugger at that instruction.
// - Breakpoint without a debugger raises a hard fault or lockup.
// - Interrupt-disable form sets the priority mask bit.
// - Interrupt-enable form clears the priority mask bit.
// - With the mask set only the non-maskable interrupt passes.
// - Processor-state changes leave the condition flags alone.
// - Breakpoint, barriers, reads, no-op and send-event keep flags.
// - After an order barrier, memory waits for earlier accesses.
// - Order barrier does not stall instructions without memory access.
// - Nothing after a sync barrier runs until the barrier completes.
// - Sync barrier completes once earlier memory accesses finish.
// - Fetch barrier flushes the pipeline so later code is refetched.
// - Special read copies a selected special register to a register.
// - Special write loads the selected register from the source.
// - Special write to a status view sets flags from source bits.
// - No-operation has no effect and may be retired at once.
// - Send-event signals all processors and sets the local event.
// - Branch if equal is taken only when the zero flag is set.
// - Call branches store the return address in the link register.
module msie_core (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  input  wire msie_pkg::msie_op_t instr_op,
  input  wire logic [7:0]        instr_imm,
  input  wire logic [7:0]        instr_sysm,
  input  wire logic [31:0]       instr_operand,
  input  wire logic [31:0]       instr_target,
  input  wire logic [31:0]       instr_pc,
  input  wire logic [31:0]       instr_next_pc,
  input  wire logic              instr_mem_access,
  output logic                   result_valid,
  output logic [31:0]            result_data,
  output logic                   branch_taken,
  output logic [31:0]            branch_target,
  output logic [31:0]            link_reg,
  output logic [3:0]             cond_flags,
  output logic                   priority_mask,
  input  wire logic              irq_request,
  input  wire logic              nmi_request,
  input  wire logic [5:0]        irq_number,
  output logic                   irq_take,
  output logic                   nmi_take,
  input  wire logic              mem_pending,
  output logic                   mem_order_hold,
  output logic                   pipeline_flush,
  output logic                   event_out,
  output logic                   local_event,
  input  wire logic              debug_attached,
  output logic                   debug_halted,
  output logic                   hard_fault,
  output logic                   lockup,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);
  import msie_pkg::*;

  msie_core_t  q;
  msie_core_t  next_q;
  logic        accept;
  logic        sync_hold;
  logic        wr_go;
  logic [31:0] status_word;
  logic [31:0] special_value;
  logic [31:0] read_word;

  // Merges a bus write into a word under its byte enables.
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Instruction handshake and barrier tracking.

  // An instruction stalls while halted, locked up or behind a barrier.
  assign instr_ready = !q.halted && !q.lockup && !sync_hold
                       && !(mem_order_hold && instr_mem_access);
  assign accept      = instr_valid && instr_ready;

  // Barrier tracker sees each barrier on the cycle it is accepted.
  msie_barrier u_barrier (
    .clock          (clock),
    .resetn         (resetn),
    .dmb_start      (accept && instr_op == op_dmb),
    .dsb_start      (accept && instr_op == op_dsb),
    .isb_start      (accept && instr_op == op_isb),
    .mem_pending    (mem_pending),
    .order_hold     (mem_order_hold),
    .sync_hold      (sync_hold),
    .pipeline_flush (pipeline_flush)
  );

  ////////////////////////////////////////////////////////////////////////
  // Special register and bus read views.

  // Selected special register for a special read.
  always_comb begin
    special_value = `MSIE_RST_WORD;
    if (instr_sysm[7:3] == 5'h00) begin
      // Status views: flags unless the application bit is off.
      special_value[31:28] = instr_sysm[2] ? 4'h0 : q.flags;
      special_value[5:0]   = instr_sysm[0] ? irq_number : 6'h00;
    end else if (instr_sysm == `MSIE_SYSM_MAIN_SP) begin
      special_value = q.main_sp;
    end else if (instr_sysm == `MSIE_SYSM_PROC_SP) begin
      special_value = q.proc_sp;
    end else if (instr_sysm == `MSIE_SYSM_PRIORITY_MASK_BIT) begin
      special_value[0] = q.priority_mask_bit;
    end else if (instr_sysm == `MSIE_SYSM_CONTROL) begin
      special_value[1:0] = q.control;
    end
  end

  // Status word that software reads.
  always_comb begin
    status_word = `MSIE_RST_WORD;
    status_word[`MSIE_ST_FLAGS_LSB +: 4] = q.flags;
    status_word[`MSIE_ST_PRIORITY_MASK_BIT]        = q.priority_mask_bit;
    status_word[`MSIE_ST_HALTED]         = q.halted;
    status_word[`MSIE_ST_LOCKUP]         = q.lockup;
    status_word[`MSIE_ST_EVENT]          = q.local_event;
    status_word[`MSIE_ST_ORDER_HOLD]     = mem_order_hold;
    status_word[`MSIE_ST_SYNC_HOLD]      = sync_hold;
  end

  // Read decode; unmapped offsets read as zero.
  always_comb begin
    unique case (avs_address)
      `MSIE_OFS_CTRL: begin
        read_word = `MSIE_RST_WORD;
        read_word[`MSIE_CTRL_BREAKPOINT_INSTR_LOCK] = q.breakpoint_instr_lock;
      end
      `MSIE_OFS_STATUS:  read_word = status_word;
      `MSIE_OFS_HALT_PC: read_word = q.halt_pc;
      `MSIE_OFS_MAIN_SP: read_word = q.main_sp;
      `MSIE_OFS_PROC_SP: read_word = q.proc_sp;
      `MSIE_OFS_CONTROL: read_word = {30'h0000_0000, q.control};
      default:           read_word = `MSIE_RST_WORD;
    endcase
  end

  // One wait cycle per access; a write lands when waitrequest is low.
  assign avs_waitrequest = (avs_read || avs_write) && !q.bus_ack;
  assign wr_go           = avs_write && q.bus_ack;

  ////////////////////////////////////////////////////////////////////////
  // Next state of the whole core.

  // Bus writes are applied first so that an instruction in the same
  // cycle wins, and every hardware set comes after any software clear.
  always_comb begin
    next_q              = q;
    next_q.result_valid = 1'b0;
    next_q.branch_taken = 1'b0;
    next_q.event_out    = 1'b0;
    next_q.hard_fault   = 1'b0;
    next_q.bus_ack      = (avs_read || avs_write) && !q.bus_ack;
    if (avs_read && !q.bus_ack) begin
      next_q.bus_rdata = read_word;
    end
    if (wr_go) begin
      unique case (avs_address)
        `MSIE_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            next_q.breakpoint_instr_lock = avs_writedata[`MSIE_CTRL_BREAKPOINT_INSTR_LOCK];
            if (avs_writedata[`MSIE_CTRL_RESUME]) begin
              next_q.halted = 1'b0;
            end
            if (avs_writedata[`MSIE_CTRL_EVENT_CLR]) begin
              next_q.local_event = 1'b0;
            end
            if (avs_writedata[`MSIE_CTRL_LOCKUP_CLR]) begin
              next_q.lockup = 1'b0;
            end
          end
        end
        `MSIE_OFS_MAIN_SP: begin
          next_q.main_sp = merge_be(q.main_sp, avs_writedata,
                                    avs_byteenable) & `MSIE_SP_ALIGN_MASK;
        end
        `MSIE_OFS_PROC_SP: begin
          next_q.proc_sp = merge_be(q.proc_sp, avs_writedata,
                                    avs_byteenable) & `MSIE_SP_ALIGN_MASK;
        end
        `MSIE_OFS_CONTROL: begin
          if (avs_byteenable[0]) begin
            next_q.control = avs_writedata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (accept) begin
      // Only the special write below ever touches the flags.
      unique case (instr_op)
        op_nop: begin
          // Retired on acceptance with no effect at all.
        end
        op_breakpoint_instr: begin
          // The immediate is deliberately not looked at.
          if (debug_attached) begin
            next_q.halted  = 1'b1;
            next_q.halt_pc = instr_pc;
          end else if (q.breakpoint_instr_lock) begin
            next_q.lockup = 1'b1;
          end else begin
            next_q.hard_fault = 1'b1;
          end
        end
        op_irq_mask_set_instr: next_q.priority_mask_bit = 1'b1;
        op_irq_mask_clear_instr: next_q.priority_mask_bit = 1'b0;
        op_dmb, op_dsb, op_isb: begin
          // Handled by the barrier tracker; flags untouched.
        end
        op_mrs: begin
          next_q.result_valid = 1'b1;
          next_q.result_data  = special_value;
        end
        op_msr: begin
          if (instr_sysm[7:3] == 5'h00) begin
            if (!instr_sysm[2]) begin
              next_q.flags = instr_operand[31:28];
            end
          end else if (instr_sysm == `MSIE_SYSM_MAIN_SP) begin
            next_q.main_sp = instr_operand & `MSIE_SP_ALIGN_MASK;
          end else if (instr_sysm == `MSIE_SYSM_PROC_SP) begin
            next_q.proc_sp = instr_operand & `MSIE_SP_ALIGN_MASK;
          end else if (instr_sysm == `MSIE_SYSM_PRIORITY_MASK_BIT) begin
            next_q.priority_mask_bit = instr_operand[0];
          end else if (instr_sysm == `MSIE_SYSM_CONTROL) begin
            next_q.control = instr_operand[1:0];
          end
        end
        op_sev: begin
          next_q.event_out   = 1'b1;
          next_q.local_event = 1'b1;
        end
        op_beq: begin
          next_q.branch_taken  = q.flags[`MSIE_FLAG_Z];
          next_q.branch_target = instr_target;
        end
        op_bl: begin
          next_q.branch_taken  = 1'b1;
          next_q.branch_target = instr_target;
          next_q.link_reg      = instr_next_pc | `MSIE_LINK_THUMB;
        end
        op_blx: begin
          // A target without its state bit set faults instead.
          if (instr_operand[0]) begin
            next_q.branch_taken  = 1'b1;
            next_q.branch_target = {instr_operand[31:1], 1'b0};
            next_q.link_reg      = instr_next_pc | `MSIE_LINK_THUMB;
          end else begin
            next_q.hard_fault = 1'b1;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The mask stops maskable requests, never the non-maskable one.
  assign irq_take = irq_request && !q.priority_mask_bit && !q.halted
                    && !q.lockup;
  assign nmi_take = nmi_request && !q.halted;

  // Registered outputs straight from the state.
  assign result_valid  = q.result_valid;
  assign result_data   = q.result_data;
  assign branch_taken  = q.branch_taken;
  assign branch_target = q.branch_target;
  assign link_reg      = q.link_reg;
  assign cond_flags    = q.flags;
  assign priority_mask = q.priority_mask_bit;
  assign event_out     = q.event_out;
  assign local_event   = q.local_event;
  assign debug_halted  = q.halted;
  assign hard_fault    = q.hard_fault;
  assign lockup        = q.lockup;
  assign avs_readdata  = q.bus_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Accepted instruction of each kind.
  sequence s_acc(msie_op_t op);
    accept && instr_op == op;
  endsequence

  // Sync barrier followed by a cycle with nothing pending.
  sequence s_dsb_done;
    s_acc(op_dsb) ##1 !mem_pending;
  endsequence

  a_breakpoint_instr_halts: assert property (
    s_acc(op_breakpoint_instr) and debug_attached |=> debug_halted && !instr_ready)
    else $error("breakpoint with debugger did not halt");
  a_breakpoint_instr_fault: assert property (
    s_acc(op_breakpoint_instr) and (!debug_attached && !q.breakpoint_instr_lock)
      |=> hard_fault && !debug_halted)
    else $error("breakpoint without debugger did not fault");
  a_mask_set: assert property (
    s_acc(op_irq_mask_set_instr) |=> priority_mask && !irq_take)
    else $error("interrupt disable did not set mask");
  a_mask_clear: assert property (
    s_acc(op_irq_mask_clear_instr) |=> !priority_mask)
    else $error("interrupt enable did not clear mask");
  a_nmi_passes: assert property (
    priority_mask && nmi_request && !debug_halted |-> nmi_take && !irq_take)
    else $error("mask did not gate interrupts correctly");
  a_flags_kept: assert property (
    accept && instr_op != op_msr |=> cond_flags == $past(cond_flags))
    else $error("flags changed by a non-writing instruction");
  a_dmb_order: assert property (
    mem_order_hold && instr_valid && instr_mem_access |-> !instr_ready)
    else $error("memory access passed an order barrier");
  a_dmb_free: assert property (
    mem_order_hold && !sync_hold && !debug_halted && !lockup
      && !instr_mem_access |-> instr_ready)
    else $error("order barrier stalled a non-memory instruction");
  a_dsb_stall: assert property (
    s_acc(op_dsb) |=> !instr_ready)
    else $error("instruction ran before sync barrier completed");
  a_dsb_done: assert property (
    s_dsb_done |=> !sync_hold ##0 !mem_order_hold)
    else $error("sync barrier did not complete");
  a_isb_flush: assert property (
    s_acc(op_isb) |=> pipeline_flush ##1 !pipeline_flush)
    else $error("fetch barrier did not flush once");
  a_mrs_mask: assert property (
    s_acc(op_mrs) and instr_sysm == `MSIE_SYSM_PRIORITY_MASK_BIT
      |=> result_valid && result_data == {31'h0, $past(priority_mask)})
    else $error("special read returned wrong mask");
  a_msr_flags: assert property (
    s_acc(op_msr) and instr_sysm == 8'h00
      |=> cond_flags == $past(instr_operand[31:28]))
    else $error("special write did not set flags");
  a_sev_event: assert property (
    s_acc(op_sev) |=> event_out && local_event)
    else $error("send event did not signal");
  a_beq_zero: assert property (
    s_acc(op_beq) |=> branch_taken == $past(cond_flags[`MSIE_FLAG_Z]))
    else $error("equal branch ignored zero flag");
  a_bl_link: assert property (
    s_acc(op_bl) |=> branch_taken
      && link_reg == ($past(instr_next_pc) | `MSIE_LINK_THUMB))
    else $error("call did not store return address");
endmodule // msie_core

/* test/msie_mem_model.sv */
// Memory system and debugger stand-in facing the executor.
`timescale 1ns/1ps
module msie_mem_model #(
  parameter logic [3:0] HOLD = 4'h6
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic access_go,
  input  wire logic dbg_present,
  output logic      mem_pending,
  output logic      debug_attached
);
  logic [3:0] left;

  // Keeps an earlier explicit access outstanding for HOLD cycles.
  always_ff @(posedge clock) begin
    if (!resetn) left <= 4'h0;
    else if (access_go) left <= HOLD;
    else if (left != 4'h0) left <= left - 4'h1;
  end

  // Pending while cycles remain; debugger presence follows the bench.
  assign mem_pending = (left != 4'h0);
  assign debug_attached = dbg_present;
endmodule // msie_mem_model

/* test/msie_core_tb.sv */
// Self-checking bench for the system instruction executor.
`timescale 1ns/1ps
`include "msie_regs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module msie_core_tb;
  import msie_pkg::*;
  logic clock = 0, resetn = 0, instr_valid = 0, instr_ready;
  msie_op_t instr_op = op_nop;
  logic [7:0] instr_sysm = '0, instr_imm;
  logic [31:0] instr_operand = '0, instr_target, instr_pc, instr_next_pc;
  logic [31:0] result_data, branch_target, link_reg, avs_readdata, rd;
  logic [31:0] avs_writedata = '0;
  logic instr_mem_access = 0, result_valid, branch_taken, priority_mask;
  logic [3:0] cond_flags, avs_byteenable = 4'hF;
  logic irq_request = 0, nmi_request = 0, irq_take, nmi_take, mem_pending;
  logic [5:0] irq_number = 6'h05;
  logic mem_order_hold, pipeline_flush, event_out, local_event;
  logic debug_attached, debug_halted, hard_fault, lockup;
  logic [4:0] avs_address = '0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest, acc_go = 0, dbg_on = 0;
  int fails = 0, comparisons = 0;

  // Device under test and the stand-in for its far side.
  msie_core dut (.clock, .resetn, .instr_valid, .instr_ready, .instr_op,
    .instr_imm, .instr_sysm, .instr_operand, .instr_target, .instr_pc,
    .instr_next_pc, .instr_mem_access, .result_valid, .result_data,
    .branch_taken, .branch_target, .link_reg, .cond_flags, .priority_mask,
    .irq_request, .nmi_request, .irq_number, .irq_take, .nmi_take,
    .mem_pending, .mem_order_hold, .pipeline_flush, .event_out,
    .local_event, .debug_attached, .debug_halted, .hard_fault, .lockup,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);
  msie_mem_model peer (.clock, .resetn, .access_go(acc_go),
                       .dbg_present(dbg_on), .mem_pending, .debug_attached);

  // Target and PC fields follow the operand; the immediate follows the selector.
  assign instr_target = instr_operand;
  assign instr_pc = instr_operand;
  assign instr_next_pc = instr_operand + 32'h0000_0002;
  assign instr_imm = instr_sysm;

  // Free-running core clock.
  always #25 clock = ~clock;

  // Prints the verdict and stops.
  task automatic end_sim();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Counts a wait that ran out and stops.
  task automatic hang();
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim();
  endtask

  // Offers one instruction and returns at the edge that takes it.
  task automatic issue(msie_op_t op, logic [7:0] s, logic [31:0] v,
                       logic m);
    int n;
    @(posedge clock);
    instr_op <= op;
    instr_sysm <= s;
    instr_operand <= v;
    instr_mem_access <= m;
    instr_valid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (instr_ready === 1'b1) break;
    end
    if (n == 20) hang();
    instr_valid <= 1'b0;
  endtask

  // One register access, completed at the edge with waitrequest low.
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) hang();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Mask set and clear, interrupt gating, special register moves.
  task automatic s_mask();
    issue(op_msr, 8'h00, 32'h5000_0000, 1'b0);
    irq_request <= 1'b1;
    nmi_request <= 1'b1;
    @(negedge clock);
    `CHK(cond_flags, 4'h5)
    issue(op_irq_mask_set_instr, 8'h00, '0, 1'b0);
    @(negedge clock);
    `CHK({priority_mask, irq_take, nmi_take}, 3'b101)
    `CHK(cond_flags, 4'h5)
    issue(op_mrs, `MSIE_SYSM_PRIORITY_MASK_BIT, '0, 1'b0);
    @(negedge clock);
    `CHK({result_valid, result_data}, 33'h1_0000_0001)
    issue(op_mrs, 8'h01, '0, 1'b0);
    @(negedge clock);
    `CHK(result_data, 32'h5000_0005)
    issue(op_irq_mask_clear_instr, 8'h00, '0, 1'b0);
    @(negedge clock);
    `CHK({priority_mask, irq_take, cond_flags}, 6'h15)
    issue(op_msr, `MSIE_SYSM_MAIN_SP, 32'h2000_0104, 1'b0);
    irq_request <= 1'b0;
    nmi_request <= 1'b0;
    bus(1'b0, `MSIE_OFS_MAIN_SP, '0);
    `CHK(rd, 32'h2000_0104)
  endtask

  // Flags survive the quiet instructions; event and flush pulses.
  task automatic s_quiet();
    msie_op_t ops[4] = '{op_nop, op_dmb, op_isb, op_mrs};
    foreach (ops[i]) begin
      issue(ops[i], 8'h10, '0, 1'b0);
      @(negedge clock);
      `CHK(cond_flags, 4'h5)
    end
    issue(op_isb, 8'h00, '0, 1'b0);
    @(negedge clock);
    `CHK(pipeline_flush, 1'b1)
    issue(op_sev, 8'h00, '0, 1'b0);
    @(negedge clock);
    `CHK({event_out, local_event, pipeline_flush}, 3'b110)
    @(negedge clock);
    `CHK({event_out, local_event}, 2'b01)
    bus(1'b1, `MSIE_OFS_CTRL, 32'h0000_0002);
    @(negedge clock);
    `CHK(local_event, 1'b0)
  endtask

  // Equal branch both ways, then calls with link, direct and indirect.
  task automatic s_branch();
    issue(op_beq, 8'h00, 32'h0000_0400, 1'b0);
    @(negedge clock);
    `CHK({branch_taken, branch_target}, 33'h1_0000_0400)
    issue(op_msr, 8'h00, '0, 1'b0);
    issue(op_beq, 8'h00, 32'h0000_0800, 1'b0);
    @(negedge clock);
    `CHK(branch_taken, 1'b0)
    issue(op_bl, 8'h00, 32'h0000_1000, 1'b0);
    @(negedge clock);
    `CHK({branch_taken, link_reg}, 33'h1_0000_1003)
    issue(op_blx, 8'h00, 32'h0000_2001, 1'b0);
    @(negedge clock);
    `CHK({branch_taken, link_reg}, 33'h1_0000_2003)
    `CHK(branch_target, 32'h0000_2000)
    issue(op_blx, 8'h00, 32'h0000_2000, 1'b0);
    @(negedge clock);
    `CHK({hard_fault, branch_taken}, 2'b10)
  endtask

  // Sync barrier waits out memory; order barrier stalls memory only.
  task automatic s_barrier();
    @(posedge clock);
    acc_go <= 1'b1;
    @(posedge clock);
    acc_go <= 1'b0;
    issue(op_dsb, 8'h00, '0, 1'b0);
    repeat (3) begin
      @(negedge clock);
      `CHK(instr_ready, 1'b0)
    end
    issue(op_nop, 8'h00, '0, 1'b0);
    @(negedge clock);
    `CHK(mem_pending, 1'b0)
    @(posedge clock);
    acc_go <= 1'b1;
    @(posedge clock);
    acc_go <= 1'b0;
    issue(op_dmb, 8'h00, '0, 1'b0);
    issue(op_nop, 8'h00, '0, 1'b0);
    @(negedge clock);
    `CHK({mem_pending, mem_order_hold}, 2'b11)
    issue(op_nop, 8'h00, '0, 1'b1);
    @(negedge clock);
    `CHK({mem_pending, mem_order_hold}, 2'b00)
  endtask

  // Breakpoint with a debugger, then without: fault and lockup.
  task automatic s_breakpoint_instr();
    @(posedge clock);
    dbg_on <= 1'b1;
    issue(op_breakpoint_instr, 8'hA7, 32'h0000_0300, 1'b0);
    @(negedge clock);
    `CHK({debug_halted, instr_ready}, 2'b10)
    bus(1'b0, `MSIE_OFS_HALT_PC, '0);
    `CHK({rd, cond_flags}, 36'h0_0000_3000)
    bus(1'b1, `MSIE_OFS_CTRL, 32'h0000_0001);
    dbg_on <= 1'b0;
    @(negedge clock);
    `CHK(debug_halted, 1'b0)
    issue(op_breakpoint_instr, 8'h00, 32'h0000_0304, 1'b0);
    @(negedge clock);
    `CHK({hard_fault, debug_halted}, 2'b10)
    bus(1'b1, `MSIE_OFS_CTRL, 32'h0000_0004);
    issue(op_breakpoint_instr, 8'hFF, 32'h0000_0308, 1'b0);
    @(negedge clock);
    `CHK(lockup, 1'b1)
    bus(1'b1, `MSIE_OFS_CTRL, 32'h0000_0008);
    @(negedge clock);
    `CHK(lockup, 1'b0)
  endtask

  // Reset, then every scenario in turn.
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, `MSIE_OFS_STATUS, '0);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, 5'h1C, '0);
    `CHK(rd, 32'h0000_0000)
    s_mask();
    s_quiet();
    s_branch();
    s_barrier();
    s_breakpoint_instr();
    end_sim();
  end
endmodule // msie_core_tb
